//--- inc/rbt_cfg.svh
// rbt_cfg.svh: constants for the registered bus transceiver
// What this block does
// - data inverted both ways across 8 bits, card to backplane and back
// - out-direction modes and a-to-b clock steer a-to-b element; in-direction likewise
// - mode bits: 00 buffer, 01 flip-flop, 1x latch
// - buffer mode passes input straight through, inverted at the port
// - flip-flop mode captures on rising clock edge, holds otherwise
// - latch mode transparent while enable high, holds while low
// - loopback low: backplane data feeds the b-to-a element
// - loopback high: a-to-b element output, before inversion, feeds b-to-a element
// - card output port released when card-output enable low
// - card output port driven when card-output enable high
// - backplane inactive when high enable low or low enable high
// - backplane active only with high enable high and low enable low
// - elements keep loading and holding while outputs disabled
// - edge-rate select high gives slow edges, low fast; static level
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH
`define RBT_W       8
`define RBT_SYN_W   27
`define RBT_F_AI    0
`define RBT_F_BI    8
`define RBT_F_OMHI  16
`define RBT_F_OMLO  17
`define RBT_F_IMHI  18
`define RBT_F_IMLO  19
`define RBT_F_CLKAB 20
`define RBT_F_CLKBA 21
`define RBT_F_LOOP  22
`define RBT_F_CARD_OUTPUT_ENABLE  23
`define RBT_F_BACKPLANE_ENABLE_PAIR  24
`define RBT_F_OEABN 25
`define RBT_F_ERC   26
`define RBT_SYN_RST 27'h0000000
`define RBT_DAT_RST 8'h00
`endif

//--- inc/rbt_pkg.sv
// rbt_pkg: types of the registered bus transceiver
`include "rbt_cfg.svh"
package rbt_pkg;
    typedef enum logic [1:0] {
        RBT_BUF = 2'h0,
        RBT_FF  = 2'h1,
        RBT_LAT = 2'h3
    } rbt_elem_t;

    typedef struct packed {
        logic [`RBT_SYN_W-1:0] s1;
        logic [`RBT_SYN_W-1:0] s2;
        logic [`RBT_SYN_W-1:0] s3;
        logic [`RBT_SYN_W-1:0] f;
        logic [`RBT_W-1:0]     p;
        logic [`RBT_W-1:0]     q;
        logic [`RBT_W-1:0]     ao;
        logic [`RBT_W-1:0]     ao_oe;
        logic [`RBT_W-1:0]     bp_o;
        logic [`RBT_W-1:0]     bp_oe;
        logic                  slow;
        rbt_elem_t             mab;
        rbt_elem_t             mba;
    } rbt_state_t;
endpackage : rbt_pkg

//--- testbench/rbt_far_bus.sv
// rbt_far_bus: terminated backplane lines shared with other cards
`timescale 1ns/1ps
`default_nettype none
module rbt_far_bus (
    // pull-down requests from the block and from other cards
    input  wire logic [7:0] dut_pull,
    input  wire logic [7:0] card_pull,
    // resolved line level
    output var  logic [7:0] line
);
    // termination lifts a released line, any driver wins low
    assign line = ~(dut_pull | card_pull);
endmodule : rbt_far_bus
`default_nettype wire

//--- testbench/rbt_top_tb.sv
// rbt_top_tb: directed scenarios for the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module rbt_top_tb;
    import rbt_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, cab = 1'b0, cba = 1'b0, lb = 1'b0;
    logic       coe = 1'b1, peh = 1'b1, pen = 1'b0, edge_rate_select = 1'b0, slow;
    logic [1:0] om = 2'h0, im = 2'h0;
    logic [7:0] ai = 8'h00, bpull = 8'h00, line, ao, aoe, bo, boe;
    rbt_elem_t  eab, eba;
    int         n_mismatch = 0, tests_run = 0;
    always #5 clk = ~clk;
    rbt_far_bus far_u (.dut_pull(boe), .card_pull(bpull), .line(line));
    rbt_top dut_u (
        .CLK(clk), .RST(rst), .CARD_INPUT_PORT(ai), .CARD_OUTPUT_PORT_O(ao),
        .CARD_OUTPUT_PORT_OE(aoe), .BACKPLANE_I(line), .BACKPLANE_O(bo), .BACKPLANE_OE(boe),
        .OUT_DIR_MODE_HI(om[1]), .OUT_DIR_MODE_LO(om[0]), .IN_DIR_MODE_HI(im[1]),
        .IN_DIR_MODE_LO(im[0]), .A_TO_B_CLOCK_LATCH_ENABLE(cab),
        .B_TO_A_CLOCK_LATCH_ENABLE(cba), .LOOPBACK_SELECT(lb), .CARD_OUTPUT_ENABLE(coe),
        .BACKPLANE_ENABLE_PAIR_H(peh), .BACKPLANE_ENABLE_PAIR_N(pen),
        .EDGE_RATE_SELECT(edge_rate_select), .SLOW_EDGES(slow), .A_TO_B_ELEMENT(eab),
        .B_TO_A_ELEMENT(eba));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // both paths chained through three-flop filters, so settle generously
    task automatic wt(input int n = 12);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic t_buf();
        @(posedge clk);
        ai <= 8'h5a;
        bpull <= 8'h81;
        wt();
        chk(boe, 8'h5a);
        chk(bo, 8'h00);
        chk(ao, 8'hdb);
        chk(aoe, 8'hff);
        chk({6'h00, eab}, 8'h00);
    endtask : t_buf
    task automatic t_ff();
        @(posedge clk);
        om <= 2'h1;
        ai <= 8'h3c;
        wt();
        cab <= 1'b1;
        wt();
        chk(boe, 8'h3c);
        chk({6'h00, eab}, 8'h01);
        ai <= 8'hc3;
        peh <= 1'b0;
        wt();
        chk(boe, 8'h00);
        cab <= 1'b0;
        wt();
        cab <= 1'b1;
        wt();
        peh <= 1'b1;
        wt();
        chk(boe, 8'hc3);
    endtask : t_ff
    task automatic t_lat();
        for (int lo = 0; lo < 2; lo++) begin
            om <= {1'b1, lo[0]};
            ai <= 8'h0f;
            wt();
            chk(boe, 8'h0f);
            chk({6'h00, eab}, 8'h03);
            cab <= 1'b0;
            wt();
            ai <= 8'hf0;
            wt();
            chk(boe, 8'h0f);
            cab <= 1'b1;
            wt();
        end
    endtask : t_lat
    task automatic t_loop();
        om <= 2'h0;
        lb <= 1'b1;
        bpull <= 8'hff;
        ai <= 8'ha5;
        wt();
        chk(ao, 8'h5a);
        im <= 2'h1;
        ai <= 8'h0f;
        cab <= 1'b0;
        wt();
        cab <= 1'b1;
        wt();
        chk(ao, 8'h5a);
        chk({6'h00, eba}, 8'h01);
        cba <= 1'b1;
        wt();
        chk(ao, 8'hf0);
        // b-to-a latch, still looped back: open, then shut
        im <= 2'h2;
        ai <= 8'h55;
        wt();
        chk(ao, 8'haa);
        chk({6'h00, eba}, 8'h03);
        cba <= 1'b0;
        wt();
        ai <= 8'h33;
        wt();
        chk(ao, 8'haa);
    endtask : t_loop
    task automatic t_en();
        coe <= 1'b0;
        wt();
        chk(aoe, 8'h00);
        coe <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            {peh, pen} <= i[1:0];
            wt();
            chk(boe, (i == 2) ? 8'h33 : 8'h00);
        end
        edge_rate_select <= 1'b1;
        wt();
        chk({7'h00, slow}, 8'h01);
        edge_rate_select <= 1'b0;
        wt();
        chk({7'h00, slow}, 8'h00);
    endtask : t_en
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_buf();
        t_ff();
        t_lat();
        t_loop();
        t_en();
        test_done();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule : rbt_top_tb
`default_nettype wire

//--- verilog/rbt_top.sv
// rbt_top: registered inverting bus transceiver between card logic and backplane
`timescale 1ns/1ps
`default_nettype none
`include "rbt_cfg.svh"
module rbt_top (
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST,
    // card side
    input  wire logic [`RBT_W-1:0]    CARD_INPUT_PORT,
    output var  logic [`RBT_W-1:0]    CARD_OUTPUT_PORT_O,
    output var  logic [`RBT_W-1:0]    CARD_OUTPUT_PORT_OE,
    // backplane, open drain
    input  wire logic [`RBT_W-1:0]    BACKPLANE_I,
    output var  logic [`RBT_W-1:0]    BACKPLANE_O,
    output var  logic [`RBT_W-1:0]    BACKPLANE_OE,
    // element modes and clocks
    input  wire logic                 OUT_DIR_MODE_HI,
    input  wire logic                 OUT_DIR_MODE_LO,
    input  wire logic                 IN_DIR_MODE_HI,
    input  wire logic                 IN_DIR_MODE_LO,
    input  wire logic                 A_TO_B_CLOCK_LATCH_ENABLE,
    input  wire logic                 B_TO_A_CLOCK_LATCH_ENABLE,
    // path controls
    input  wire logic                 LOOPBACK_SELECT,
    input  wire logic                 CARD_OUTPUT_ENABLE,
    input  wire logic                 BACKPLANE_ENABLE_PAIR_H,
    input  wire logic                 BACKPLANE_ENABLE_PAIR_N,
    input  wire logic                 EDGE_RATE_SELECT,
    // status
    output var  logic                 SLOW_EDGES,
    output var  rbt_pkg::rbt_elem_t   A_TO_B_ELEMENT,
    output var  rbt_pkg::rbt_elem_t   B_TO_A_ELEMENT
);
    import rbt_pkg::*;

    localparam rbt_state_t RST_STATE = '{
        s1: `RBT_SYN_RST, s2: `RBT_SYN_RST, s3: `RBT_SYN_RST, f: `RBT_SYN_RST,
        p: `RBT_DAT_RST, q: `RBT_DAT_RST, ao: `RBT_DAT_RST, ao_oe: `RBT_DAT_RST,
        bp_o: `RBT_DAT_RST, bp_oe: `RBT_DAT_RST, slow: 1'b0,
        mab: RBT_BUF, mba: RBT_BUF
    };

    function automatic rbt_elem_t elem_sel(input logic hi, input logic lo);
        if (hi) begin
            elem_sel = RBT_LAT;
        end else if (lo) begin
            elem_sel = RBT_FF;
        end else begin
            elem_sel = RBT_BUF;
        end
    endfunction : elem_sel

    // one element step: buffer follows, flip-flop on rise, latch while enable high
    function automatic logic [`RBT_W-1:0] elem_step(
        input rbt_elem_t         m,
        input logic              ce_now,
        input logic              ce_was,
        input logic [`RBT_W-1:0] d,
        input logic [`RBT_W-1:0] held
    );
        case (m)
            RBT_BUF: elem_step = d;
            RBT_FF:  elem_step = (ce_now && !ce_was) ? d : held;
            RBT_LAT: elem_step = ce_now ? d : held;
            default: elem_step = held;
        endcase
    endfunction : elem_step

    rbt_state_t r;
    rbt_state_t n;

    logic [`RBT_SYN_W-1:0] pins;
    logic [`RBT_W-1:0]     ai_f;
    logic [`RBT_W-1:0]     bi_f;
    logic [`RBT_W-1:0]     q_in;
    logic                  bp_active;

    assign pins = {EDGE_RATE_SELECT, BACKPLANE_ENABLE_PAIR_N, BACKPLANE_ENABLE_PAIR_H,
                   CARD_OUTPUT_ENABLE, LOOPBACK_SELECT,
                   B_TO_A_CLOCK_LATCH_ENABLE, A_TO_B_CLOCK_LATCH_ENABLE,
                   IN_DIR_MODE_LO, IN_DIR_MODE_HI, OUT_DIR_MODE_LO, OUT_DIR_MODE_HI,
                   BACKPLANE_I, CARD_INPUT_PORT};

    always_comb begin
        n = r;
        // pins are asynchronous: three stages, a change counts once s2 and s3 agree
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.f  = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
        ai_f = n.f[`RBT_F_AI +: `RBT_W];
        bi_f = n.f[`RBT_F_BI +: `RBT_W];
        n.mab = elem_sel(n.f[`RBT_F_OMHI], n.f[`RBT_F_OMLO]);
        n.mba = elem_sel(n.f[`RBT_F_IMHI], n.f[`RBT_F_IMLO]);
        // elements run whatever the enables say
        n.p = elem_step(n.mab, n.f[`RBT_F_CLKAB], r.f[`RBT_F_CLKAB],
                        ai_f, r.p);
        // loopback taps the a-to-b element before its inverter
        q_in = n.f[`RBT_F_LOOP] ? n.p : bi_f;
        n.q = elem_step(n.mba, n.f[`RBT_F_CLKBA], r.f[`RBT_F_CLKBA],
                        q_in, r.q);
        n.ao    = ~n.q;
        n.ao_oe = {`RBT_W{n.f[`RBT_F_CARD_OUTPUT_ENABLE]}};
        bp_active = n.f[`RBT_F_BACKPLANE_ENABLE_PAIR] & ~n.f[`RBT_F_OEABN];
        // inverted bit low means element bit high: pull that line low
        n.bp_o  = `RBT_DAT_RST;
        n.bp_oe = {`RBT_W{bp_active}} & n.p;
        n.slow  = n.f[`RBT_F_ERC];
        if (RST) begin
            n = RST_STATE;
        end
    end

    always_ff @(posedge CLK) begin
        r <= n;
    end

    assign CARD_OUTPUT_PORT_O  = r.ao;
    assign CARD_OUTPUT_PORT_OE = r.ao_oe;
    assign BACKPLANE_O         = r.bp_o;
    assign BACKPLANE_OE        = r.bp_oe;
    assign SLOW_EDGES          = r.slow;
    assign A_TO_B_ELEMENT      = r.mab;
    assign B_TO_A_ELEMENT      = r.mba;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    logic [`RBT_W-1:0] ai_r;
    logic [`RBT_W-1:0] bi_r;
    logic              ab_ce;
    logic              ba_ce;
    logic              loop_r;
    logic              bp_on_r;
    assign ai_r    = r.f[`RBT_F_AI +: `RBT_W];
    assign bi_r    = r.f[`RBT_F_BI +: `RBT_W];
    assign ab_ce   = r.f[`RBT_F_CLKAB];
    assign ba_ce   = r.f[`RBT_F_CLKBA];
    assign loop_r  = r.f[`RBT_F_LOOP];
    assign bp_on_r = r.f[`RBT_F_BACKPLANE_ENABLE_PAIR] & ~r.f[`RBT_F_OEABN];

    sequence ab_rise_s;
        !ab_ce ##1 ab_ce;
    endsequence
    sequence erc_steady_s;
        $stable(EDGE_RATE_SELECT) [*4];
    endsequence

    mode_decode_a: assert property (r.f[`RBT_F_OMHI] |-> r.mab == RBT_LAT
        && (r.f[`RBT_F_IMHI] ? r.mba == RBT_LAT : r.mba != RBT_LAT))
        else $error("mode decode wrong");
    ab_buffer_a: assert property (r.mab == RBT_BUF |-> r.p == ai_r)
        else $error("buffer not following input");
    ff_capture_a: assert property (ab_rise_s ##0 r.mab == RBT_FF |-> r.p == ai_r)
        else $error("flip-flop missed edge");
    ff_hold_a: assert property ((r.mab == RBT_FF && $past(r.mab) == RBT_FF
        && !(ab_ce && !$past(ab_ce))) |-> r.p == $past(r.p))
        else $error("flip-flop changed without edge");
    latch_path_a: assert property (r.mba == RBT_LAT |->
        (ba_ce ? r.q == (loop_r ? r.p : bi_r) : r.q == $past(r.q)))
        else $error("latch misbehaves");
    loop_path_a: assert property (r.mba == RBT_BUF |-> r.q == (loop_r ? r.p : bi_r))
        else $error("b-to-a source wrong");
    // reset state clears data and output alike, so skip the cycle right after it
    card_out_a: assert property (!$past(RST) |-> CARD_OUTPUT_PORT_O == ~r.q
        && CARD_OUTPUT_PORT_OE == {`RBT_W{r.f[`RBT_F_CARD_OUTPUT_ENABLE]}})
        else $error("card output wrong");
    bp_drive_a: assert property (##1 BACKPLANE_O == `RBT_DAT_RST
        && BACKPLANE_OE == ({`RBT_W{bp_on_r}} & r.p))
        else $error("backplane drive wrong");
    erc_level_a: assert property (erc_steady_s |-> SLOW_EDGES == EDGE_RATE_SELECT)
        else $error("edge rate not following select");

    // second group: filter stages, each element on its own, enables
    logic [`RBT_SYN_W-1:0] s1_q;
    logic [`RBT_SYN_W-1:0] s2_q;
    logic [`RBT_SYN_W-1:0] s3_q;
    logic [`RBT_SYN_W-1:0] f_q;
    logic [`RBT_W-1:0]     p_q;
    logic [`RBT_W-1:0]     q_q;
    logic [`RBT_W-1:0]     b2a_src;
    logic                  ab_hold;
    logic                  ba_hold;
    assign s1_q    = r.s1;
    assign s2_q    = r.s2;
    assign s3_q    = r.s3;
    assign f_q     = r.f;
    assign p_q     = r.p;
    assign q_q     = r.q;
    // what the b-to-a element should be looking at this cycle
    assign b2a_src = loop_r ? r.p : bi_r;
    // enable low now: no rise possible, a flip-flop must keep its word
    assign ab_hold = !ab_ce;
    assign ba_hold = !ba_ce;

    sequence ba_rise_s;
        !ba_ce ##1 ba_ce;
    endsequence

    sequence ab_low_s;
        !ab_ce ##1 !ab_ce;
    endsequence

    // each stage takes the one before it, one edge later
    stage_two_a: assert property (s2_q == $past(s1_q))
        else $error("filter stage two did not shift");

    stage_three_a: assert property (s3_q == $past(s2_q))
        else $error("filter stage three did not shift");

    // a bit moves only once the last two stages agree
    filter_agree_a: assert property (f_q == (($past(s2_q) & $past(s3_q))
        | ($past(f_q) & ($past(s2_q) | $past(s3_q)))))
        else $error("filtered pin value wrong");

    // short glitches must never reach the elements
    glitch_reject_a: assert property (((f_q ^ $past(f_q))
        & ($past(s2_q) ^ $past(s3_q))) == `RBT_SYN_RST)
        else $error("filter passed a disagreeing bit");

    ab_buf_sel_a: assert property ((!f_q[`RBT_F_OMHI] && !f_q[`RBT_F_OMLO])
        |-> r.mab == RBT_BUF)
        else $error("a-to-b buffer not selected");

    ab_ff_sel_a: assert property ((!f_q[`RBT_F_OMHI] && f_q[`RBT_F_OMLO])
        |-> r.mab == RBT_FF)
        else $error("a-to-b flip-flop not selected");

    ba_buf_sel_a: assert property ((!f_q[`RBT_F_IMHI] && !f_q[`RBT_F_IMLO])
        |-> r.mba == RBT_BUF)
        else $error("b-to-a buffer not selected");

    ba_ff_sel_a: assert property ((!f_q[`RBT_F_IMHI] && f_q[`RBT_F_IMLO])
        |-> r.mba == RBT_FF)
        else $error("b-to-a flip-flop not selected");

    ba_lat_sel_a: assert property (f_q[`RBT_F_IMHI] |-> r.mba == RBT_LAT)
        else $error("b-to-a latch not selected");

    ab_ff_keep_a: assert property ((r.mab == RBT_FF && ab_hold)
        |-> p_q == $past(p_q))
        else $error("a-to-b flip-flop lost its word");

    ab_latch_on_a: assert property ((r.mab == RBT_LAT && ab_ce)
        |-> p_q == ai_r)
        else $error("a-to-b latch not transparent");

    ab_latch_off_a: assert property (ab_low_s ##0 r.mab == RBT_LAT
        |-> p_q == $past(p_q))
        else $error("a-to-b latch did not hold");

    // the b-to-a element runs whether or not the card port drives
    ba_ff_keep_a: assert property ((r.mba == RBT_FF && ba_hold)
        |-> q_q == $past(q_q))
        else $error("b-to-a flip-flop lost its word");

    ba_ff_cap_a: assert property (ba_rise_s ##0 r.mba == RBT_FF
        |-> q_q == b2a_src)
        else $error("b-to-a flip-flop missed edge");

    bp_idle_a: assert property (!bp_on_r |-> BACKPLANE_OE == `RBT_DAT_RST)
        else $error("backplane pulled while inactive");

    bp_pull_a: assert property (bp_on_r |-> BACKPLANE_OE == p_q)
        else $error("backplane pull pattern wrong");

    card_off_a: assert property (!f_q[`RBT_F_CARD_OUTPUT_ENABLE]
        |-> CARD_OUTPUT_PORT_OE == `RBT_DAT_RST)
        else $error("card port driven while disabled");

    card_on_a: assert property (f_q[`RBT_F_CARD_OUTPUT_ENABLE]
        |-> CARD_OUTPUT_PORT_OE == 8'hff)
        else $error("card port not driven while enabled");

    // the reset state is not a settled data state, hence the guard
    loop_high_a: assert property ((!$past(RST) && loop_r && r.mba == RBT_BUF)
        |-> CARD_OUTPUT_PORT_O == ~p_q)
        else $error("loopback word not at card output");

    loop_low_a: assert property ((!$past(RST) && !loop_r && r.mba == RBT_BUF)
        |-> CARD_OUTPUT_PORT_O == ~bi_r)
        else $error("backplane word not at card output");

    slow_track_a: assert property (SLOW_EDGES == f_q[`RBT_F_ERC])
        else $error("edge rate output off its filtered pin");
endmodule : rbt_top
`default_nettype wire
